// ===== rpir_bench.sv
// Self-checking bench for the receiver in FIFO mode and decode mode
`timescale 1ns/1ps
`include "rpir_defs.svh"
module rpir_bench;
    import rpir_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, fwd_data_o, mwr_data_i, fwd_d, lfsr_q = 32'h3748ce1d, prdata2;
    logic [63:0] mwr_addr_i, fwd_addr_o, fwd_a;
    logic [3:0] dec2_m = 4'h0;
    logic irq2, lo2, hi2, sel2 = 1'b0;
    logic pready_o, pslverr_o, intx_valid_i, intx_assert_i, mwr_valid_i, fwd_valid_o;
    logic interrupt_out_o, msi_low_vectors_irq_o, msi_high_vectors_irq_o, ovf_m = 1'b0;
    rpir_line_t intx_line_i;
    int fails = 0, tests_run = 0, fwd_n = 0;
    logic [31:0] exp_q[$], msk_q[$], dat_q[$];
    always #10 clk_sys_i = ~clk_sys_i;
    rpir_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .intx_valid_i(intx_valid_i), .intx_line_i(intx_line_i), .intx_assert_i(intx_assert_i),
        .mwr_valid_i(mwr_valid_i), .mwr_addr_i(mwr_addr_i), .mwr_data_i(mwr_data_i),
        .fwd_valid_o(fwd_valid_o), .fwd_addr_o(fwd_addr_o), .fwd_data_o(fwd_data_o),
        .interrupt_out_o(interrupt_out_o), .msi_low_vectors_irq_o(msi_low_vectors_irq_o),
        .msi_high_vectors_irq_o(msi_high_vectors_irq_o));
    rpir_endpoint_model ep_u (.clk_sys_i(clk_sys_i), .intx_valid_o(intx_valid_i),
        .intx_line_o(intx_line_i), .intx_assert_o(intx_assert_i), .mwr_valid_o(mwr_valid_i),
        .mwr_addr_o(mwr_addr_i), .mwr_data_o(mwr_data_i));
    rpir_top #(.MODE(RPIR_MODE_DECODE)) dec_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata2), .pready_o(), .pslverr_o(),
        .intx_valid_i(intx_valid_i), .intx_line_i(intx_line_i), .intx_assert_i(intx_assert_i),
        .mwr_valid_i(mwr_valid_i), .mwr_addr_i(mwr_addr_i), .mwr_data_i(mwr_data_i),
        .fwd_valid_o(), .fwd_addr_o(), .fwd_data_o(), .interrupt_out_o(irq2),
        .msi_low_vectors_irq_o(lo2), .msi_high_vectors_irq_o(hi2));
    always @(negedge clk_sys_i) begin
        if (fwd_valid_o === 1'b1) begin
            fwd_n++;
            fwd_d = fwd_data_o;
            fwd_a = fwd_addr_o;
        end
    end
    // =====================================================
    // Compare, bus and model helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_pin
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = sel2 ? prdata2 : prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(d & m, exp);
    endtask : rd_chk
    task automatic push(input logic [31:0] f1, input logic [31:0] m, input logic [31:0] dt);
        if (exp_q.size() < `RPIR_FIFO_DEPTH) begin
            exp_q.push_back(f1);
            msk_q.push_back(m);
            dat_q.push_back(dt);
        end else begin
            ovf_m = 1'b1;
        end
    endtask : push
    task automatic intx(input logic [1:0] line, input logic a);
        ep_u.send_intx(line, a);
        dec2_m[line] = a;
        push({2'b00, a, 27'h0, line}, 32'h6000_0003, 32'h0);
    endtask : intx
    task automatic drain();
        while (exp_q.size() > 0) begin
            rd_chk(`RPIR_OFF_FIFO1, exp_q.pop_front(), msk_q.pop_front());
            rd_chk(`RPIR_OFF_FIFO2, dat_q.pop_front(), 32'hffff_ffff);
            wr(`RPIR_OFF_FIFO1, 32'h8000_0000);
        end
        rd_chk(`RPIR_OFF_STATUS, {12'h0, ovf_m, 19'h0}, 32'h000c_0000);
    endtask : drain
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #400000;
        fails++;
        tally_and_finish();
    end
    // =====================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic e;
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_chk(`RPIR_OFF_STATUS, 32'h0, 32'hffff_ffff);
        rd_chk(`RPIR_OFF_DECODE, 32'h0, 32'hffff_ffff);
        apb(1'b0, 12'h03c, 32'h0, d, e);
        chk_pin(e, 1'b1);
        $display("test reset values done");
        wr(`RPIR_OFF_MSI_BASE_LO, 32'h0000_a000);
        wr(`RPIR_OFF_MSI_BASE_HI, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            intx(i[1:0], lfsr_q[0]);
        end
        chk_pin(interrupt_out_o, 1'b0);
        ep_u.send_mwr({32'h1, 20'h0000a, lfsr_q[11:0]}, lfsr_q);
        push(32'h4000_0000, 32'h4000_0000, lfsr_q);
        chk(fwd_n, 0);
        ep_u.send_mwr({32'h1, 20'h0000b, 12'h000}, ~lfsr_q);
        chk(fwd_n, 1);
        chk(fwd_d, ~lfsr_q);
        chk(fwd_a[43:12], 32'h0010_000b);
        rd_chk(`RPIR_OFF_DECODE, 32'h0003_0000, 32'h0003_0000);
        rd_chk(`RPIR_OFF_STATUS, 32'h0004_0000, 32'h000c_0000);
        wr(`RPIR_OFF_MASK, 32'h0001_0000);
        chk_pin(interrupt_out_o, 1'b1);
        wr(`RPIR_OFF_MASK, 32'h0);
        chk_pin(interrupt_out_o, 1'b0);
        drain();
        wr(`RPIR_OFF_DECODE, 32'h0001_0000);
        rd_chk(`RPIR_OFF_DECODE, 32'h0002_0000, 32'h0003_0000);
        wr(`RPIR_OFF_MASK, 32'h0003_0000);
        chk_pin(interrupt_out_o, 1'b1);
        wr(`RPIR_OFF_DECODE, 32'h0002_0000);
        chk_pin(interrupt_out_o, 1'b0);
        $display("test fifo service done");
        for (int i = 0; i < 17; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            intx(lfsr_q[1:0], lfsr_q[2]);
        end
        chk_pin(interrupt_out_o, 1'b1);
        drain();
        wr(`RPIR_OFF_STATUS, 32'h0008_0000);
        rd_chk(`RPIR_OFF_STATUS, 32'h0, 32'h000c_0000);
        wr(`RPIR_OFF_DECODE, 32'h0001_0000);
        chk_pin(interrupt_out_o, 1'b0);
        $display("test overflow done");
        sel2 = 1'b1;
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(`RPIR_OFF_DEC2_MASK, {28'h0, lfsr_q[7:4]});
            intx(i[1:0], i < 4 && lfsr_q[2]);
            rd_chk(`RPIR_OFF_DEC2, {28'h0, dec2_m}, 32'hf);
            chk_pin(irq2, |(dec2_m & lfsr_q[7:4]));
        end
        wr(`RPIR_OFF_MSI_MASK1, 32'hffff_ffff);
        wr(`RPIR_OFF_MSI_MASK2, 32'hffff_ffff);
        for (int i = 0; i < 3; i++) begin
            wr(`RPIR_OFF_MSI_DEC1, 32'hffff_ffff);
            wr(`RPIR_OFF_MSI_DEC2, 32'hffff_ffff);
            chk_pin(lo2 | hi2, 1'b0);
            if (i == 2) break;
            lfsr_q = lfsr_next(lfsr_q);
            d = {lfsr_q[31:6], i[0], lfsr_q[4:0]};
            ep_u.send_mwr({32'h1, 20'h0000a, d[11:0]}, d);
            rd_chk(i[0] ? `RPIR_OFF_MSI_DEC2 : `RPIR_OFF_MSI_DEC1, 32'h1 << d[4:0],
                   32'hffff_ffff);
            chk({30'h0, hi2, lo2}, {30'h0, i[0], !i[0]});
        end
        $display("test decode mode done");
        tally_and_finish();
    end
endmodule : rpir_bench

// ===== rpir_defs.svh
// Constants and the behaviour summary of the root port interrupt receiver
// Behaviour
// - Build-time choice: FIFO mode default, decode mode
// - FIFO mode INTx sets decode bit 16, masked
// - Status bit 18 not empty, bit 19 overflow
// - FIFO read 1 returns head line and kind
// - Write 1 to bit 31 pops head
// - Decode bit 16 is write-one-to-clear
// - Writes in 4 KB window above base are MSI
// - FIFO mode MSI sets decode bit 17, masked
// - FIFO read 2 returns head MSI data
// - Decode bit 17 write-one-to-clear; mask re-enables
// - Writes outside window forwarded to master port
// - Decode mode INTx assert sets line bit, masked
// - INTx deassert clears the line bit
// - Vector number is always message data 5:0
// - Vectors 0-31 low pin, 32-63 high pin
// - MSI decode bits write-one-to-clear, masks gate
`ifndef RPIR_DEFS_SVH
`define RPIR_DEFS_SVH
`define RPIR_ADDR_W 12
`define RPIR_OFF_STATUS 12'h000
`define RPIR_OFF_DECODE 12'h004
`define RPIR_OFF_MASK 12'h008
`define RPIR_OFF_FIFO1 12'h00c
`define RPIR_OFF_FIFO2 12'h010
`define RPIR_OFF_MSI_BASE_LO 12'h014
`define RPIR_OFF_MSI_BASE_HI 12'h018
`define RPIR_OFF_DEC2 12'h01c
`define RPIR_OFF_DEC2_MASK 12'h020
`define RPIR_OFF_MSI_DEC1 12'h024
`define RPIR_OFF_MSI_DEC2 12'h028
`define RPIR_OFF_MSI_MASK1 12'h02c
`define RPIR_OFF_MSI_MASK2 12'h030
`define RPIR_BIT_INTX 16
`define RPIR_BIT_MSI 17
`define RPIR_BIT_NOT_EMPTY 18
`define RPIR_BIT_OVERFLOW 19
`define RPIR_BIT_POP 31
`define RPIR_BIT_FIFO_MSI 30
`define RPIR_BIT_FIFO_ASSERT 29
`define RPIR_FIFO_DEPTH 16
`define RPIR_FIFO_PTR_W 4
`define RPIR_FIFO_CNT_W 5
`define RPIR_MSI_WIN_BITS 12
`define RPIR_VEC_BITS 6
`define RPIR_VEC_HALF 32
`endif

// ===== rpir_endpoint_model.sv
// Endpoint-side model issuing INTx messages and memory writes
`timescale 1ns/1ps
module rpir_endpoint_model (
    input wire logic clk_sys_i,
    output logic intx_valid_o,
    output rpir_pkg::rpir_line_t intx_line_o,
    output logic intx_assert_o,
    output logic mwr_valid_o,
    output logic [63:0] mwr_addr_o,
    output logic [31:0] mwr_data_o
);
    import rpir_pkg::*;
    initial begin
        intx_valid_o = 1'b0;
        intx_line_o = RPIR_INTA;
        intx_assert_o = 1'b0;
        mwr_valid_o = 1'b0;
        mwr_addr_o = 64'h0;
        mwr_data_o = 32'h0;
    end
    // =====================================================
    // One-cycle strobes; qualifiers are inverted once released so stale values never match
    task automatic send_intx(input logic [1:0] line, input logic asrt);
        intx_valid_o <= 1'b1;
        intx_line_o <= rpir_line_t'(line);
        intx_assert_o <= asrt;
        @(posedge clk_sys_i);
        intx_valid_o <= 1'b0;
        intx_line_o <= rpir_line_t'(~line);
        intx_assert_o <= ~asrt;
        @(posedge clk_sys_i);
    endtask : send_intx
    task automatic send_mwr(input logic [63:0] addr, input logic [31:0] data);
        mwr_valid_o <= 1'b1;
        mwr_addr_o <= addr;
        mwr_data_o <= data;
        @(posedge clk_sys_i);
        mwr_valid_o <= 1'b0;
        mwr_addr_o <= ~addr;
        mwr_data_o <= ~data;
        @(posedge clk_sys_i);
    endtask : send_mwr
endmodule : rpir_endpoint_model

// ===== rpir_fifo.sv
// Interrupt message FIFO with overflow flag, flip-flop storage
`timescale 1ns/1ps
`include "rpir_defs.svh"
module rpir_fifo (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic push_i,
    input rpir_pkg::rpir_entry_t entry_i,
    input wire logic pop_i,
    input wire logic ovf_clr_i,
    output rpir_pkg::rpir_entry_t head_o,
    output logic not_empty_o,
    output logic overflow_o
);
    import rpir_pkg::*;

    typedef struct packed {
        rpir_entry_t [`RPIR_FIFO_DEPTH-1:0] mem;
        logic [`RPIR_FIFO_PTR_W-1:0] wr;
        logic [`RPIR_FIFO_PTR_W-1:0] rd;
        logic [`RPIR_FIFO_CNT_W-1:0] cnt;
        logic ovf;
    } rpir_fifo_st_t;

    rpir_fifo_st_t s_q;
    rpir_fifo_st_t s_d;

    always_comb begin
        logic do_pop;
        logic do_push;
        do_pop = pop_i && (s_q.cnt != '0);
        do_push = push_i && (do_pop || s_q.cnt != `RPIR_FIFO_CNT_W'(`RPIR_FIFO_DEPTH));
        s_d = s_q;
        if (do_push) begin
            s_d.mem[s_q.wr] = entry_i;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (do_pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        if (do_push && !do_pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        // Lost entries are remembered; a fresh loss wins over the clear
        if (ovf_clr_i) begin
            s_d.ovf = 1'b0;
        end
        if (push_i && !do_push) begin
            s_d.ovf = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign head_o = s_q.mem[s_q.rd];
    assign not_empty_o = (s_q.cnt != '0);
    assign overflow_o = s_q.ovf;
endmodule : rpir_fifo

// ===== rpir_pkg.sv
// Types shared by the root port interrupt receiver files
package rpir_pkg;
    typedef enum logic [1:0] {
        RPIR_INTA,
        RPIR_INTB,
        RPIR_INTC,
        RPIR_INTD
    } rpir_line_t;

    typedef enum logic {
        RPIR_MODE_FIFO,
        RPIR_MODE_DECODE
    } rpir_mode_t;

    typedef struct packed {
        logic is_msi;
        logic asserted;
        logic [1:0] line;
        logic [31:0] data;
    } rpir_entry_t;
endpackage : rpir_pkg

// ===== rpir_top.sv
// Root port interrupt receiver: INTx and MSI decode, FIFO, APB registers
`timescale 1ns/1ps
`include "rpir_defs.svh"
module rpir_top #(
    parameter rpir_pkg::rpir_mode_t MODE = rpir_pkg::RPIR_MODE_FIFO
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`RPIR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Received INTx message (one-cycle strobe)
    input wire logic intx_valid_i,
    input rpir_pkg::rpir_line_t intx_line_i,
    input wire logic intx_assert_i,
    // Received memory write TLP (one-cycle strobe)
    input wire logic mwr_valid_i,
    input wire logic [63:0] mwr_addr_i,
    input wire logic [31:0] mwr_data_i,
    // Forwarded write toward the master port
    output logic fwd_valid_o,
    output logic [63:0] fwd_addr_o,
    output logic [31:0] fwd_data_o,
    // Interrupt outputs
    output logic interrupt_out_o,
    output logic msi_low_vectors_irq_o,
    output logic msi_high_vectors_irq_o
);
    import rpir_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        logic slverr;
        logic dec_intx;
        logic dec_msi;
        logic mask_intx;
        logic mask_msi;
        logic [31:0] base_lo;
        logic [31:0] base_hi;
        logic [3:0] dec2;
        logic [3:0] dec2_mask;
        logic [31:0] msi_dec1;
        logic [31:0] msi_dec2;
        logic [31:0] msi_mask1;
        logic [31:0] msi_mask2;
        logic fwd_valid;
        logic [63:0] fwd_addr;
        logic [31:0] fwd_data;
        logic irq;
        logic irq_lo;
        logic irq_hi;
    } rpir_st_t;

    rpir_st_t s_q;
    rpir_st_t s_d;

    // MSI window hit: the upper address bits equal the programmed base
    function automatic logic rpir_in_window(input logic [63:0] a, input logic [63:0] b);
        rpir_in_window = (a[63:`RPIR_MSI_WIN_BITS] == b[63:`RPIR_MSI_WIN_BITS]);
    endfunction : rpir_in_window

    // Write-one-to-clear with the hardware set taking priority
    function automatic logic [31:0] rpir_w1c(input logic [31:0] cur, input logic [31:0] clr,
                                             input logic [31:0] set);
        rpir_w1c = (cur & ~clr) | set;
    endfunction : rpir_w1c

    logic apb_wr;
    logic apb_rd;
    logic msi_hit;
    logic msi_evt;
    logic intx_fifo_evt;
    logic fifo_pop;
    logic fifo_ovf_clr;
    logic fifo_not_empty;
    logic fifo_overflow;
    rpir_entry_t fifo_in;
    rpir_entry_t fifo_head;

    // Zero-wait slave: every access completes in its first access cycle
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign apb_rd = psel_i && penable_i && !pwrite_i;
    assign pready_o = 1'b1;

    assign msi_hit = mwr_valid_i && rpir_in_window(mwr_addr_i, {s_q.base_hi, s_q.base_lo});
    assign msi_evt = msi_hit;
    assign intx_fifo_evt = (MODE == RPIR_MODE_FIFO) && intx_valid_i;

    // FIFO entry carries line, kind and MSI data
    always_comb begin
        fifo_in = '0;
        fifo_in.is_msi = msi_evt;
        fifo_in.asserted = intx_assert_i;
        fifo_in.line = intx_line_i;
        fifo_in.data = mwr_data_i;
    end

    // MSI is queued in preference when both arrive together; the INTx is still latched
    assign fifo_pop = apb_wr && paddr_i == `RPIR_OFF_FIFO1 && pstrb_i[3]
                      && pwdata_i[`RPIR_BIT_POP];
    assign fifo_ovf_clr = apb_wr && paddr_i == `RPIR_OFF_STATUS && pstrb_i[2]
                          && pwdata_i[`RPIR_BIT_OVERFLOW];

    rpir_fifo u_fifo (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .push_i((MODE == RPIR_MODE_FIFO) && (msi_evt || intx_fifo_evt)),
        .entry_i(fifo_in),
        .pop_i(fifo_pop),
        .ovf_clr_i(fifo_ovf_clr),
        .head_o(fifo_head),
        .not_empty_o(fifo_not_empty),
        .overflow_o(fifo_overflow)
    );

    always_comb begin
        logic [31:0] wmask;
        logic [31:0] vec_set;
        logic [31:0] clr;
        logic [`RPIR_VEC_BITS-1:0] vec;
        logic [3:0] line_bit;
        logic [31:0] dec_word;
        wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
        vec_set = '0;
        clr = '0;
        vec = mwr_data_i[`RPIR_VEC_BITS-1:0];
        line_bit = 4'h1 << intx_line_i;
        dec_word = '0;
        s_d = s_q;
        s_d.slverr = 1'b0;

        // Forward writes outside the MSI window unchanged to the master side
        s_d.fwd_valid = mwr_valid_i && !msi_hit;
        if (mwr_valid_i && !msi_hit) begin
            s_d.fwd_addr = mwr_addr_i;
            s_d.fwd_data = mwr_data_i;
        end

        // Register writes
        if (apb_wr) begin
            unique case (paddr_i)
                `RPIR_OFF_DECODE: begin
                    clr = pwdata_i & wmask;
                    s_d.dec_intx = s_q.dec_intx & ~clr[`RPIR_BIT_INTX];
                    s_d.dec_msi = s_q.dec_msi & ~clr[`RPIR_BIT_MSI];
                end
                `RPIR_OFF_MASK: begin
                    if (pstrb_i[2]) begin
                        s_d.mask_intx = pwdata_i[`RPIR_BIT_INTX];
                        s_d.mask_msi = pwdata_i[`RPIR_BIT_MSI];
                    end
                end
                `RPIR_OFF_MSI_BASE_LO: begin
                    s_d.base_lo = (s_q.base_lo & ~wmask) | (pwdata_i & wmask);
                end
                `RPIR_OFF_MSI_BASE_HI: begin
                    s_d.base_hi = (s_q.base_hi & ~wmask) | (pwdata_i & wmask);
                end
                `RPIR_OFF_DEC2_MASK: begin
                    if (pstrb_i[0]) begin
                        s_d.dec2_mask = pwdata_i[3:0];
                    end
                end
                `RPIR_OFF_MSI_DEC1: begin
                    s_d.msi_dec1 = s_q.msi_dec1 & ~(pwdata_i & wmask);
                end
                `RPIR_OFF_MSI_DEC2: begin
                    s_d.msi_dec2 = s_q.msi_dec2 & ~(pwdata_i & wmask);
                end
                `RPIR_OFF_MSI_MASK1: begin
                    s_d.msi_mask1 = (s_q.msi_mask1 & ~wmask) | (pwdata_i & wmask);
                end
                `RPIR_OFF_MSI_MASK2: begin
                    s_d.msi_mask2 = (s_q.msi_mask2 & ~wmask) | (pwdata_i & wmask);
                end
                `RPIR_OFF_STATUS, `RPIR_OFF_FIFO1, `RPIR_OFF_FIFO2, `RPIR_OFF_DEC2: begin
                    s_d.slverr = 1'b0;
                end
                default: begin
                    s_d.slverr = 1'b1;
                end
            endcase
        end

        // Hardware sets come after the clears so an event in the clear cycle survives
        if (MODE == RPIR_MODE_FIFO) begin
            if (intx_valid_i) begin
                s_d.dec_intx = 1'b1;
            end
            if (msi_evt) begin
                s_d.dec_msi = 1'b1;
            end
        end else begin
            if (intx_valid_i && intx_assert_i) begin
                s_d.dec2 = s_d.dec2 | line_bit;
            end else if (intx_valid_i) begin
                s_d.dec2 = s_d.dec2 & ~line_bit;
            end
            if (msi_evt) begin
                vec_set = 32'h1 << vec[`RPIR_VEC_BITS-2:0];
                if (vec >= `RPIR_VEC_BITS'(`RPIR_VEC_HALF)) begin
                    s_d.msi_dec2 = rpir_w1c(s_d.msi_dec2, '0, vec_set);
                end else begin
                    s_d.msi_dec1 = rpir_w1c(s_d.msi_dec1, '0, vec_set);
                end
            end
        end

        // Level outputs from latched bits and masks
        s_d.irq = (MODE == RPIR_MODE_FIFO)
                  ? ((s_d.dec_intx && s_d.mask_intx) || (s_d.dec_msi && s_d.mask_msi))
                  : |(s_d.dec2 & s_d.dec2_mask);
        s_d.irq_lo = |(s_d.msi_dec1 & s_d.msi_mask1);
        s_d.irq_hi = |(s_d.msi_dec2 & s_d.msi_mask2);

        // Read data, sampled in the setup cycle so it is stable in the access phase
        if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                `RPIR_OFF_STATUS: begin
                    dec_word[`RPIR_BIT_NOT_EMPTY] = fifo_not_empty;
                    dec_word[`RPIR_BIT_OVERFLOW] = fifo_overflow;
                end
                `RPIR_OFF_DECODE: begin
                    dec_word[`RPIR_BIT_INTX] = s_q.dec_intx;
                    dec_word[`RPIR_BIT_MSI] = s_q.dec_msi;
                end
                `RPIR_OFF_MASK: begin
                    dec_word[`RPIR_BIT_INTX] = s_q.mask_intx;
                    dec_word[`RPIR_BIT_MSI] = s_q.mask_msi;
                end
                `RPIR_OFF_FIFO1: begin
                    if (fifo_not_empty) begin
                        dec_word[`RPIR_BIT_FIFO_MSI] = fifo_head.is_msi;
                        dec_word[`RPIR_BIT_FIFO_ASSERT] = fifo_head.asserted;
                        dec_word[1:0] = fifo_head.line;
                    end
                end
                `RPIR_OFF_FIFO2: begin
                    if (fifo_not_empty && fifo_head.is_msi) begin
                        dec_word = fifo_head.data;
                    end
                end
                `RPIR_OFF_MSI_BASE_LO: dec_word = s_q.base_lo;
                `RPIR_OFF_MSI_BASE_HI: dec_word = s_q.base_hi;
                `RPIR_OFF_DEC2: dec_word[3:0] = s_q.dec2;
                `RPIR_OFF_DEC2_MASK: dec_word[3:0] = s_q.dec2_mask;
                `RPIR_OFF_MSI_DEC1: dec_word = s_q.msi_dec1;
                `RPIR_OFF_MSI_DEC2: dec_word = s_q.msi_dec2;
                `RPIR_OFF_MSI_MASK1: dec_word = s_q.msi_mask1;
                `RPIR_OFF_MSI_MASK2: dec_word = s_q.msi_mask2;
                default: s_d.slverr = 1'b1;
            endcase
            s_d.rdata = dec_word;
        end else if (apb_rd) begin
            s_d.slverr = s_q.slverr;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Error reported only in the access phase; write errors are decoded combinationally
    assign pslverr_o = psel_i && penable_i
                       && (pwrite_i ? !(paddr_i inside {`RPIR_OFF_STATUS, `RPIR_OFF_DECODE,
                           `RPIR_OFF_MASK, `RPIR_OFF_FIFO1, `RPIR_OFF_FIFO2,
                           `RPIR_OFF_MSI_BASE_LO, `RPIR_OFF_MSI_BASE_HI, `RPIR_OFF_DEC2,
                           `RPIR_OFF_DEC2_MASK, `RPIR_OFF_MSI_DEC1, `RPIR_OFF_MSI_DEC2,
                           `RPIR_OFF_MSI_MASK1, `RPIR_OFF_MSI_MASK2}) : s_q.slverr);
    assign prdata_o = s_q.rdata;
    assign fwd_valid_o = s_q.fwd_valid;
    assign fwd_addr_o = s_q.fwd_addr;
    assign fwd_data_o = s_q.fwd_data;
    assign interrupt_out_o = s_q.irq;
    assign msi_low_vectors_irq_o = s_q.irq_lo;
    assign msi_high_vectors_irq_o = s_q.irq_hi;
endmodule : rpir_top

// ===== rpir_top_properties.sv
// Port-level checker for the root port interrupt receiver
`timescale 1ns/1ps
`include "rpir_defs.svh"
module rpir_top_properties #(
    parameter rpir_pkg::rpir_mode_t MODE = rpir_pkg::RPIR_MODE_FIFO
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`RPIR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic intx_valid_i,
    input wire logic mwr_valid_i,
    input wire logic [63:0] mwr_addr_i,
    input wire logic [31:0] mwr_data_i,
    input wire logic fwd_valid_o,
    input wire logic [63:0] fwd_addr_o,
    input wire logic [31:0] fwd_data_o,
    input wire logic interrupt_out_o,
    input wire logic msi_low_vectors_irq_o,
    input wire logic msi_high_vectors_irq_o
);
    import rpir_pkg::*;
    localparam bit FIFO_MODE = (MODE == RPIR_MODE_FIFO);
    logic [1:0] mask_q;
    logic apb_wr;
    assign apb_wr = psel_i && penable_i && pwrite_i;
    // =====================================================
    // Shadow of the FIFO-mode mask bits 16 and 17
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mask_q <= 2'b00;
        end else if (apb_wr && paddr_i == `RPIR_OFF_MASK && pstrb_i[2]) begin
            mask_q <= pwdata_i[17:16];
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    // =====================================================
    // Properties
    sequence s_msi_kept;
        mwr_valid_i && mask_q[1] ##1 !fwd_valid_o;
    endsequence
    a_intx_raises_irq: assert property (FIFO_MODE && intx_valid_i && mask_q[0] |=>
        interrupt_out_o) else $error("interrupt line stayed low after INTx");
    a_msi_raises_irq: assert property (s_msi_kept |-> interrupt_out_o || !FIFO_MODE)
        else $error("interrupt line stayed low after MSI");
    a_mask_off_quiet: assert property (FIFO_MODE && mask_q == 2'b00 |-> !interrupt_out_o)
        else $error("interrupt line high with masks off");
    a_irq_rise_cause: assert property ($rose(interrupt_out_o) |->
        $past(intx_valid_i || mwr_valid_i || apb_wr)) else $error("interrupt rose without cause");
    a_irq_fall_cause: assert property ($fell(interrupt_out_o) |-> $past(apb_wr)
        || !FIFO_MODE && $past(intx_valid_i)) else $error("interrupt fell without cause");
    a_fwd_only_mwr: assert property (fwd_valid_o |-> $past(mwr_valid_i))
        else $error("forward without memory write");
    a_fwd_copy_data: assert property (fwd_valid_o |-> fwd_data_o == $past(mwr_data_i)
        && fwd_addr_o == $past(mwr_addr_i)) else $error("forwarded write altered");
    a_intx_no_fwd: assert property (intx_valid_i && !mwr_valid_i |=> !fwd_valid_o)
        else $error("INTx produced a forward");
    a_vec_pins_quiet: assert property (FIFO_MODE |->
        !msi_low_vectors_irq_o && !msi_high_vectors_irq_o) else $error("vector pin in FIFO mode");
endmodule : rpir_top_properties

bind rpir_top rpir_top_properties #(.MODE(MODE)) props_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .intx_valid_i(intx_valid_i), .mwr_valid_i(mwr_valid_i), .mwr_addr_i(mwr_addr_i),
    .mwr_data_i(mwr_data_i), .fwd_valid_o(fwd_valid_o), .fwd_addr_o(fwd_addr_o),
    .fwd_data_o(fwd_data_o), .interrupt_out_o(interrupt_out_o),
    .msi_low_vectors_irq_o(msi_low_vectors_irq_o),
    .msi_high_vectors_irq_o(msi_high_vectors_irq_o));
